// ### bench/rtcsp_checker.sv
// Checker for the serial link between the host and device ends.
`default_nettype none
module rtcsp_checker #(
    parameter int WDOG_CYCLES = rtcsp_pkg::WDOG_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Serial link
    input wire logic ce,
    input wire logic sck,
    input wire logic miso,
    input wire logic miso_oe,
    // Device side
    input wire logic [5:0] loc_addr,
    input wire logic loc_rd,
    input wire logic loc_wr,
    input wire logic wdog_en,
    input wire logic processor_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic idle, sck_q, ce_q, wr_seen;
    logic [5:0] last_wr;
    logic [3:0] trail_age, lead_age;
    logic [7:0] tog;
    int quiet;

    // Idle level follows sck while deselected, so it holds the level seen at select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle <= 1'b0;
            sck_q <= 1'b0;
            trail_age <= 4'hf;
            lead_age <= 4'hf;
        end else begin
            sck_q <= sck;
            if (!ce) idle <= sck;
            if (ce && sck_q != idle && sck == idle) trail_age <= 4'h0;
            else if (trail_age != 4'hf) trail_age <= trail_age + 4'h1;
            if (ce && sck_q == idle && sck != idle) lead_age <= 4'h0;
            else if (lead_age != 4'hf) lead_age <= lead_age + 4'h1;
        end
    end

    // Burst address history and clock toggles within one select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_seen <= 1'b0;
            last_wr <= 6'h00;
            tog <= 8'h00;
        end else begin
            if (loc_wr) last_wr <= loc_addr;
            if (!ce) wr_seen <= 1'b0;
            else if (loc_wr) wr_seen <= 1'b1;
            if (!ce) tog <= 8'h00;
            else if (sck != sck_q) tog <= tog + 8'h01;
        end
    end

    // Raw quiet time; the design sees ce through a synchroniser, hence the slack below
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_q <= 1'b0;
            quiet <= 0;
        end else begin
            ce_q <= ce;
            if (!wdog_en || ce != ce_q) quiet <= 0;
            else if (quiet < WDOG_CYCLES + 16) quiet <= quiet + 1;
        end
    end

    property p_off_deselected; !ce [*4] |-> !miso_oe; endproperty
    property p_idle_deselected; !ce [*6] |-> !loc_wr && !loc_rd; endproperty
    property p_write_quiet; loc_wr |-> !miso_oe; endproperty
    property p_oe_after_fetch; $rose(miso_oe) |-> $past(loc_rd, 1) || $past(loc_rd, 2); endproperty
    property p_on_trailing; loc_wr || loc_rd |-> trail_age <= 4'h8; endproperty
    property p_burst_step;
        loc_wr && wr_seen |-> loc_addr == {last_wr[5], last_wr[4:0] + 5'h1};
    endproperty
    property p_whole_bytes; $fell(ce) |-> tog[3:0] == 4'h0; endproperty
    property p_shift_lead; miso_oe && $changed(miso) |-> lead_age <= 4'h8; endproperty
    property p_wdog_fires; quiet == WDOG_CYCLES + 8 |-> processor_reset_out; endproperty
    property p_wdog_late; $rose(processor_reset_out) |-> quiet >= WDOG_CYCLES - 4; endproperty
    property p_wdog_gated; !wdog_en [*3] |-> !processor_reset_out; endproperty

    a_off_deselected: assert property (p_off_deselected) else $error("miso driven");
    a_idle_deselected: assert property (p_idle_deselected) else $error("access");
    a_write_quiet: assert property (p_write_quiet) else $error("miso in write");
    a_oe_after_fetch: assert property (p_oe_after_fetch) else $error("early oe");
    a_on_trailing: assert property (p_on_trailing) else $error("access timing");
    a_burst_step: assert property (p_burst_step) else $error("bad step");
    a_whole_bytes: assert property (p_whole_bytes) else $error("odd clocks");
    a_shift_lead: assert property (p_shift_lead) else $error("miso off edge");
    a_wdog_fires: assert property (p_wdog_fires) else $error("no reset out");
    a_wdog_late: assert property (p_wdog_late) else $error("reset out early");
    a_wdog_gated: assert property (p_wdog_gated) else $error("reset out held");

    c_burst: cover property (loc_wr && wr_seen);
    c_read: cover property ($rose(miso_oe));
    c_wdog: cover property ($rose(processor_reset_out));
endmodule : rtcsp_checker
`default_nettype wire

// ### bench/testbench.sv
// Testbench: host and device ends joined over the serial link, driven over APB.
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
    $display("FAIL %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WD = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, slv;
    logic pready, pslverr, loc_rd, loc_wr, loc_rd2, loc_wr2, rst2, processor_reset_out;
    logic wdog_en = 1'b0;
    logic [5:0] loc_addr, loc_addr2;
    logic [7:0] loc_rdata = 8'h00;
    logic [7:0] loc_wdata, loc_wdata2;
    logic [7:0] wa[2] = '{8'hde, 8'hbf};
    logic [7:0] ra[2] = '{8'h1e, 8'h3f};
    logic [13:0] wq[$];
    logic [13:0] e, got;
    logic [4:0] l;
    int err_count = 0;
    int check_count = 0;
    int wr2_count = 0;
    rtcsp_if lnk ();
    rtcsp_if lnk2 ();

    rtcsp_host rtcsp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(lnk.master));
    rtcsp_device #(.WDOG_CYCLES(WD)) rtcsp_device_inst (.pclk(pclk), .presetn(presetn),
        .lnk(lnk.slave), .loc_addr(loc_addr), .loc_rd(loc_rd), .loc_rdata(loc_rdata),
        .loc_wr(loc_wr), .loc_wdata(loc_wdata), .wdog_en(wdog_en),
        .processor_reset_out(processor_reset_out));
    // Second device faces a bench driver that cuts a byte short
    rtcsp_device #(.WDOG_CYCLES(WD)) rtcsp_device_inst2 (.pclk(pclk), .presetn(presetn),
        .lnk(lnk2.slave), .loc_addr(loc_addr2), .loc_rd(loc_rd2), .loc_rdata(8'h00),
        .loc_wr(loc_wr2), .loc_wdata(loc_wdata2), .wdog_en(1'b0), .processor_reset_out(rst2));
    rtcsp_checker #(.WDOG_CYCLES(WD)) rtcsp_checker_inst (.pclk(pclk), .presetn(presetn),
        .ce(lnk.ce), .sck(lnk.sck), .miso(lnk.miso), .miso_oe(lnk.miso_oe),
        .loc_addr(loc_addr), .loc_rd(loc_rd), .loc_wr(loc_wr), .wdog_en(wdog_en),
        .processor_reset_out(processor_reset_out));

    // Clock
    always #5 pclk = ~pclk;

    // Location store: fixed pattern of the address, data ready the cycle after a fetch
    always @(posedge pclk) begin
        if (loc_rd) loc_rdata <= {2'b00, loc_addr} ^ 8'h5a;
        if (loc_wr) wq.push_back({loc_addr, loc_wdata});
        if (loc_wr2) wr2_count++;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits for idle and for ce to settle, since a select while ce is high is dropped
    task automatic cmd(input logic [1:0] c);
        apb(1'b1, rtcsp_pkg::OFS_CMD, {30'h0, c});
        do apb(1'b0, rtcsp_pkg::OFS_STATUS, 32'h0);
        while (rd[rtcsp_pkg::ST_BUSY_BIT] !== 1'b0
            || rd[rtcsp_pkg::ST_CE_BIT] !== (c != rtcsp_pkg::CMD_DESELECT));
    endtask : cmd

    task automatic xfer(input logic [7:0] tx);
        apb(1'b1, rtcsp_pkg::OFS_TXDATA, {24'h0, tx});
        cmd(rtcsp_pkg::CMD_BYTE);
        apb(1'b0, rtcsp_pkg::OFS_RXDATA, 32'h0);
    endtask : xfer

    // Bench master on the second link: data moves with the leading edge, so it stands at trailing;
    // moving it at trailing would race the capture through the same synchroniser
    task automatic bb(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            repeat (20) @(posedge pclk);
            lnk2.sck <= 1'b1;
            lnk2.mosi <= v[i];
            repeat (20) @(posedge pclk);
            lnk2.sck <= 1'b0;
        end
        repeat (20) @(posedge pclk);
    endtask : bb

    task automatic end_of_test();
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    initial begin
        lnk2.ce = 1'b0;
        lnk2.sck = 1'b0;
        lnk2.mosi = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rtcsp_pkg::OFS_CONFIG, 32'h0);
        `CHK("config", 32'h0, rd)
        apb(1'b0, rtcsp_pkg::OFS_STATUS, 32'h0);
        `CHK("status", 32'h0, rd & 32'h3)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("slverr", 32'h1, slv)
        // Write bursts across the top of both spaces; test bit set in the clock case
        foreach (wa[k]) begin
            cmd(rtcsp_pkg::CMD_SELECT);
            xfer(wa[k]);
            for (int j = 0; j < 3; j++) xfer(8'ha1 + 8'h11 * 8'(j));
            cmd(rtcsp_pkg::CMD_DESELECT);
            for (int j = 0; j < 3; j++) begin
                l = wa[k][4:0] + 5'(j);
                e = {wa[k][5], l, 8'ha1 + 8'h11 * 8'(j)};
                got = wq.pop_front();
                `CHK("write", e, got)
            end
        end
        // Read bursts with the idle clock high
        apb(1'b1, rtcsp_pkg::OFS_CONFIG, 32'h1);
        foreach (ra[k]) begin
            cmd(rtcsp_pkg::CMD_SELECT);
            xfer(ra[k]);
            for (int j = 0; j < 3; j++) begin
                xfer(8'h00);
                l = ra[k][4:0] + 5'(j);
                `CHK("read", {2'b00, ra[k][5], l} ^ 8'h5a, rd[7:0])
            end
            cmd(rtcsp_pkg::CMD_DESELECT);
        end
        `CHK("stray writes", 0, wq.size())
        // Watchdog kept quiet by toggles, then starved, then disabled
        apb(1'b1, rtcsp_pkg::OFS_CONFIG, 32'h0);
        wdog_en <= 1'b1;
        repeat (3) begin
            cmd(rtcsp_pkg::CMD_SELECT);
            cmd(rtcsp_pkg::CMD_DESELECT);
            repeat (WD / 2) @(posedge pclk);
        end
        `CHK("wdog quiet", 1'b0, processor_reset_out)
        repeat (WD + 20) @(posedge pclk);
        `CHK("wdog fired", 1'b1, processor_reset_out)
        wdog_en <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("wdog off", 1'b0, processor_reset_out)
        // Partial data byte dropped, then a whole one accepted
        lnk2.ce <= 1'b1;
        bb(8'h85, 8);
        bb(8'hff, 5);
        lnk2.ce <= 1'b0;
        repeat (20) @(posedge pclk);
        `CHK("partial", 0, wr2_count)
        `CHK("miso off", 1'b0, lnk2.miso_oe)
        lnk2.ce <= 1'b1;
        bb(8'h85, 8);
        bb(8'h3c, 8);
        lnk2.ce <= 1'b0;
        repeat (20) @(posedge pclk);
        `CHK("whole", 1, wr2_count)
        `CHK("data", 14'h053c, {loc_addr2, loc_wdata2})
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

// ### inc/rtcsp_if.sv
// Serial link between the bus master and the clock chip's slave port.
`default_nettype none
interface rtcsp_if;
    logic ce;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Undriven data line reads low
    assign miso_line = miso_oe & miso;

    modport master (output ce, output sck, output mosi, input miso_line);
    modport slave (input ce, input sck, input mosi, output miso, output miso_oe);
endinterface : rtcsp_if
`default_nettype wire

// ### inc/rtcsp_pkg.sv
// Shared constants for the serial slave port of the clock chip and its master.
`default_nettype none
package rtcsp_pkg;
    // Serial framing
    localparam int BYTE_BITS = 8;
    localparam int WR_BIT = 7;
    localparam int TEST_BIT = 6;
    localparam int SPACE_BIT = 5;
    localparam int LOC_BITS = 5;
    // Clock rate and serial timing
    localparam int CLK_NS = 10;
    localparam int SCK_HALF_NS = 200;
    localparam int CE_SETUP_NS = 100;
    localparam int CE_HOLD_NS = 125;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CE_SETUP_CYCLES = (CE_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CE_HOLD_CYCLES = (CE_HOLD_NS + CLK_NS - 1) / CLK_NS;
    // Watchdog timeout between chip-select toggles
    localparam int WDOG_TIMEOUT_US = 100000;
    localparam int WDOG_CYCLES = WDOG_TIMEOUT_US * (1000 / CLK_NS);
    // Controller register offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_TXDATA = 8'h04;
    localparam logic [7:0] OFS_RXDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CONFIG = 8'h10;
    // Controller commands and field positions
    localparam logic [1:0] CMD_SELECT = 2'h1;
    localparam logic [1:0] CMD_BYTE = 2'h2;
    localparam logic [1:0] CMD_DESELECT = 2'h3;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_CE_BIT = 1;
    localparam int ST_FIRST_BIT = 2;
    localparam logic [7:0] TX_RESET = 8'h00;
    localparam logic RECOVER_POL_RESET = 1'b0;
endpackage : rtcsp_pkg
`default_nettype wire

// ### verilog/rtcsp_device.sv
// Slave end: serial port of the clock chip with location access and watchdog.
// Notes on behaviour
// - Serial clock edges capture and shift bits.
// - Address and data travel MSB first.
// - Chip select low resets port, MISO off.
// - Clock and data inputs keep last level.
// - Chip select defaults low when undriven.
// - Idle clock level sampled at select.
// - Master shifts on leading, captures trailing.
// - One clock per bit, eight-bit groups.
// - Master clocks only during transfers.
// - First byte is address; reselect for new.
// - Bit 7 set writes, clear reads.
// - Master sends bit 6 as zero.
// - Bit 5 picks clock or RAM space.
// - Bits 4..0 give the location.
// - Address byte then one or more data.
// - MISO off until read byte ready.
// - Bytes repeat until master deselects.
// - Address increments after every data byte.
// - Increment wraps within selected space.
// - Missing select toggles raise processor reset.
// - Watchdog only when enable set.
`default_nettype none
module rtcsp_device #(
    parameter int WDOG_CYCLES = rtcsp_pkg::WDOG_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Serial link
    rtcsp_if.slave lnk,
    // Location access
    output logic [5:0] loc_addr,
    output logic loc_rd,
    input wire logic [7:0] loc_rdata,
    output logic loc_wr,
    output logic [7:0] loc_wdata,
    // Watchdog
    input wire logic wdog_en,
    output logic processor_reset_out
);
    typedef enum logic [2:0] {
        PH_ADDR = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ = 3'b100
    } rtcsp_phase_t;

    rtcsp_phase_t phase;
    logic [2:0] sync_q;
    logic ce_s;
    logic sck_s;
    logic mosi_s;
    logic ce_d;
    logic sck_d;
    logic idle_clock_polarity;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [5:0] loc;
    logic rd_d;
    logic sel_start;
    logic lead;
    logic trail;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [5:0] next_loc;
    logic [31:0] wd_cnt;

    // Pins come from another clock; sampled flops hold the last level seen
    rtcsp_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({lnk.ce, lnk.sck, lnk.mosi}),
        .q(sync_q)
    );

    assign ce_s = sync_q[2];
    assign sck_s = sync_q[1];
    assign mosi_s = sync_q[0];

    // Edge classification against the idle level
    assign sel_start = ce_s & ~ce_d;
    assign lead = ce_s & ~sel_start & (sck_s != sck_d) & (sck_s != idle_clock_polarity);
    assign trail = ce_s & ~sel_start & (sck_s != sck_d) & (sck_s == idle_clock_polarity);
    assign byte_done = trail & (bit_cnt == 3'h7);
    assign rx_byte = {rx_sh[6:0], mosi_s};
    assign next_loc = {loc[5], loc[4:0] + 5'h01};

    // Previous sampled levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_d <= 1'b0;
            sck_d <= 1'b0;
        end else begin
            ce_d <= ce_s;
            sck_d <= sck_s;
        end
    end

    // Idle level is whatever the clock rests at when selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_clock_polarity <= rtcsp_pkg::RECOVER_POL_RESET;
        end else if (sel_start) begin
            idle_clock_polarity <= sck_s;
        end
    end

    // Bit counter; deselect drops any partial byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 3'h0;
        end else if (!ce_s) begin
            bit_cnt <= 3'h0;
        end else if (trail) begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // Inbound shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sh <= 8'h00;
        end else if (!ce_s) begin
            rx_sh <= 8'h00;
        end else if (trail) begin
            rx_sh <= rx_byte;
        end
    end

    // Address byte first, then data until deselect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= PH_ADDR;
        end else if (!ce_s) begin
            phase <= PH_ADDR;
        end else begin
            case (phase)
                PH_ADDR: begin
                    if (byte_done) begin
                        phase <= rx_byte[rtcsp_pkg::WR_BIT] ? PH_WRITE : PH_READ;
                    end
                end
                PH_WRITE: begin
                    phase <= PH_WRITE;
                end
                PH_READ: begin
                    phase <= PH_READ;
                end
                default: begin
                    phase <= PH_ADDR;
                end
            endcase
        end
    end

    // Latched location; test bit is not decoded here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc <= 6'h00;
        end else if (byte_done && phase == PH_ADDR) begin
            loc <= {rx_byte[rtcsp_pkg::SPACE_BIT], rx_byte[rtcsp_pkg::LOC_BITS-1:0]};
        end else if (byte_done) begin
            loc <= next_loc;
        end
    end

    // Write strobe only for a complete data byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_wr <= 1'b0;
            loc_wdata <= 8'h00;
        end else begin
            loc_wr <= byte_done && phase == PH_WRITE && ce_s;
            if (byte_done && phase == PH_WRITE) begin
                loc_wdata <= rx_byte;
            end
        end
    end

    // Read fetch after the address byte and after each read byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_rd <= 1'b0;
        end else begin
            loc_rd <= byte_done && ((phase == PH_ADDR && !rx_byte[rtcsp_pkg::WR_BIT])
                || phase == PH_READ);
        end
    end

    // Location presented with each strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_addr <= 6'h00;
        end else if (byte_done && phase == PH_ADDR) begin
            loc_addr <= {rx_byte[rtcsp_pkg::SPACE_BIT], rx_byte[rtcsp_pkg::LOC_BITS-1:0]};
        end else if (byte_done && phase == PH_WRITE) begin
            loc_addr <= loc;
        end else if (byte_done && phase == PH_READ) begin
            loc_addr <= next_loc;
        end
    end

    // Read data arrives one cycle after the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_d <= 1'b0;
        end else begin
            rd_d <= loc_rd & ce_s;
        end
    end

    // Outbound shifter; loads well before the next leading edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh <= 8'h00;
            lnk.miso <= 1'b0;
        end else if (!ce_s) begin
            tx_sh <= 8'h00;
            lnk.miso <= 1'b0;
        end else if (rd_d) begin
            tx_sh <= loc_rdata;
        end else if (lead && phase == PH_READ) begin
            lnk.miso <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    // Driver stays off through address and write cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk.miso_oe <= 1'b0;
        end else if (!ce_s) begin
            lnk.miso_oe <= 1'b0;
        end else if (rd_d && phase == PH_READ) begin
            lnk.miso_oe <= 1'b1;
        end
    end

    // Any select edge restarts the watchdog window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt <= 32'h0;
        end else if (!wdog_en || ce_s != ce_d) begin
            wd_cnt <= 32'h0;
        end else if (wd_cnt < 32'(WDOG_CYCLES)) begin
            wd_cnt <= wd_cnt + 32'h1;
        end
    end

    // Reset output holds until the watchdog is disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_reset_out <= 1'b0;
        end else if (wdog_en && wd_cnt == 32'(WDOG_CYCLES)) begin
            processor_reset_out <= 1'b1;
        end else if (!wdog_en) begin
            processor_reset_out <= 1'b0;
        end
    end
endmodule : rtcsp_device
`default_nettype wire

// ### verilog/rtcsp_host.sv
// Master end: APB-programmed serial controller for the clock chip's port.
`default_nettype none
module rtcsp_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    rtcsp_if.master lnk
);
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_WAIT = 5'b00010,
        H_LEAD = 5'b00100,
        H_TRAIL = 5'b01000,
        H_DESEL = 5'b10000
    } rtcsp_hstate_t;

    rtcsp_hstate_t state;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] sh;
    logic [2:0] bits;
    logic [7:0] timer;
    logic pol;
    logic first;
    logic miso_s;
    logic wr_en;
    logic mapped;
    logic [1:0] cmd;

    rtcsp_sync #(.W(1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(lnk.miso_line),
        .q(miso_s)
    );

    // Zero-wait slave; unmapped offsets flag an error
    assign pready = 1'b1;
    assign mapped = paddr == rtcsp_pkg::OFS_CMD || paddr == rtcsp_pkg::OFS_TXDATA
        || paddr == rtcsp_pkg::OFS_RXDATA || paddr == rtcsp_pkg::OFS_STATUS
        || paddr == rtcsp_pkg::OFS_CONFIG;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped;
    assign cmd = (wr_en && paddr == rtcsp_pkg::OFS_CMD) ? pwdata[1:0] : 2'h0;

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                rtcsp_pkg::OFS_TXDATA: prdata <= {24'h0, tx_data};
                rtcsp_pkg::OFS_RXDATA: prdata <= {24'h0, rx_data};
                rtcsp_pkg::OFS_STATUS: prdata <= {29'h0, first, lnk.ce, state != H_IDLE};
                rtcsp_pkg::OFS_CONFIG: prdata <= {31'h0, pol};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Software-held settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= rtcsp_pkg::TX_RESET;
            pol <= rtcsp_pkg::RECOVER_POL_RESET;
        end else if (wr_en && paddr == rtcsp_pkg::OFS_TXDATA) begin
            tx_data <= pwdata[7:0];
        end else if (wr_en && paddr == rtcsp_pkg::OFS_CONFIG && !lnk.ce) begin
            pol <= pwdata[0];
        end
    end

    // Link sequencer; commands while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= H_IDLE;
            lnk.ce <= 1'b0;
            lnk.sck <= 1'b0;
            lnk.mosi <= 1'b0;
            sh <= 8'h00;
            bits <= 3'h0;
            timer <= 8'h00;
            first <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            if (timer != 8'h00) begin
                timer <= timer - 8'h01;
            end
            case (state)
                H_IDLE: begin
                    lnk.sck <= pol;
                    if (cmd == rtcsp_pkg::CMD_SELECT && !lnk.ce) begin
                        lnk.ce <= 1'b1;
                        first <= 1'b1;
                        timer <= 8'(rtcsp_pkg::CE_SETUP_CYCLES);
                        state <= H_WAIT;
                    end else if (cmd == rtcsp_pkg::CMD_BYTE && lnk.ce) begin
                        sh <= first ? (tx_data & ~(8'h01 << rtcsp_pkg::TEST_BIT)) : tx_data;
                        first <= 1'b0;
                        bits <= 3'h0;
                        state <= H_LEAD;
                    end else if (cmd == rtcsp_pkg::CMD_DESELECT && lnk.ce) begin
                        timer <= 8'(rtcsp_pkg::CE_HOLD_CYCLES);
                        state <= H_DESEL;
                    end
                end
                H_WAIT: begin
                    if (timer == 8'h00) begin
                        state <= H_IDLE;
                    end
                end
                H_LEAD: begin
                    if (timer == 8'h00) begin
                        lnk.sck <= ~pol;
                        lnk.mosi <= sh[7];
                        sh <= {sh[6:0], 1'b0};
                        timer <= 8'(rtcsp_pkg::SCK_HALF_CYCLES - 1);
                        state <= H_TRAIL;
                    end
                end
                H_TRAIL: begin
                    if (timer == 8'h00) begin
                        lnk.sck <= pol;
                        rx_data <= {rx_data[6:0], miso_s};
                        bits <= bits + 3'h1;
                        timer <= 8'(rtcsp_pkg::SCK_HALF_CYCLES - 1);
                        state <= (bits == 3'h7) ? H_WAIT : H_LEAD;
                    end
                end
                H_DESEL: begin
                    if (timer == 8'h00) begin
                        lnk.ce <= 1'b0;
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end
endmodule : rtcsp_host
`default_nettype wire

// ### verilog/rtcsp_sync.sv
// Two-flop synchroniser for a group of independent levels.
`default_nettype none
module rtcsp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : rtcsp_sync
`default_nettype wire
